// >>> core/pld_power_state_control.sv
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module pld_power_state_control #(
   parameter int NUM_CELLS = 8,
   parameter int NUM_IN = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Board pins
   input wire logic clk_pin,
   input wire logic oe_pin_b,
   input wire logic sleep_pin,
   input wire logic [NUM_IN-1:0] in_pin,
   input wire logic [NUM_IN-1:0] in_driven,
   // Macrocell pins, oe low while driving
   input wire logic [NUM_CELLS-1:0] io_in,
   input wire logic [NUM_CELLS-1:0] io_driven,
   output logic [NUM_CELLS-1:0] io_out,
   output logic [NUM_CELLS-1:0] io_oe_b,
   // Product term array
   input wire logic [8*NUM_CELLS-1:0] product_terms,
   output logic [NUM_IN+NUM_CELLS:0] array_in
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   pld_power_pkg::cfg_type cfg_reg, cfg_next;
   logic [2*NUM_CELLS-1:0] cell_cfg_reg, cell_cfg_next;
   logic [63:0] sig_reg, sig_next;
   logic [31:0] prdata_reg, prdata_next;
   logic preload_go;
   logic [NUM_CELLS-1:0] preload_val, preload_mask;

   pld_power_pkg::power_state_type state_reg, state_next;
   logic [pld_power_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic [NUM_CELLS-1:0] cell_reg, cell_next;
   logic [NUM_CELLS-1:0] out_reg, out_next;
   logic [NUM_CELLS-1:0] oe_b_reg, oe_b_next;
   logic [NUM_IN-1:0] in_keep_reg, in_keep_next;
   logic [NUM_CELLS-1:0] io_keep_reg, io_keep_next;
   logic [NUM_IN+NUM_CELLS:0] array_reg, array_next;
   logic clk_q_reg, clk_q_next;
   logic oe_q_reg, oe_q_next;

   logic sleep_req, clock_ok, output_ok, clk_rise;
   logic [pld_power_pkg::CNT_W-1:0] clk_valid_cnt, out_valid_cnt;

   // Sum of the logic terms; with seven set, the eighth term is spent on enable
   function automatic logic term_sum(input logic [7:0] pt,
                                     input logic seven);
      term_sum = seven ? |pt[6:0] : |pt;
   endfunction

   // Cell holds a flip-flop only in the registered mode
   function automatic logic is_reg_cell(input logic [1:0] mode,
                                        input logic [1:0] kind);
      is_reg_cell = (mode == pld_power_pkg::MODE_REGISTERED) &&
                    (kind == pld_power_pkg::CELL_REG_OUT);
   endfunction

   // ***************************************************************
   // APB register file
   // ***************************************************************
   assign pready = 1'b1;
   assign prdata = prdata_reg;

   // Read data is captured in setup, so access answers at once
   always_comb begin
      logic wr;
      logic rd_setup;
      logic acc;
      wr = 1'b0;
      rd_setup = 1'b0;
      acc = psel & penable;
      cfg_next = cfg_reg;
      cell_cfg_next = cell_cfg_reg;
      sig_next = sig_reg;
      prdata_next = prdata_reg;
      preload_go = 1'b0;
      preload_val = pwdata[NUM_CELLS-1:0];
      preload_mask = pwdata[pld_power_pkg::PRELOAD_MASK_POS +: NUM_CELLS];
      pslverr = 1'b0;
      wr = acc & pwrite;
      rd_setup = psel & ~penable & ~pwrite;
      case (paddr)
         pld_power_pkg::CTRL_OFFSET: begin
            if (wr) begin
               // One mode at a time; the fourth code is not a mode
               if (pwdata[pld_power_pkg::CTRL_MODE_POS +: 2] !=
                   2'h3) begin
                  cfg_next.mode = pwdata[pld_power_pkg::CTRL_MODE_POS +: 2];
               end
               cfg_next.sleep_en = pwdata[pld_power_pkg::CTRL_SLEEP_EN_POS];
               cfg_next.speed_slow = pwdata[pld_power_pkg::CTRL_SLOW_POS];
               // Lock is one-way, only the power-up reset undoes it
               cfg_next.lock = cfg_reg.lock |
                               pwdata[pld_power_pkg::CTRL_LOCK_POS];
            end
         end
         pld_power_pkg::CELL_CFG_OFFSET: begin
            if (wr) begin
               cell_cfg_next = pwdata[2*NUM_CELLS-1:0];
            end
         end
         pld_power_pkg::PRELOAD_OFFSET: begin
            // Reads refused; writes refused when locked, clearing, asleep or waking
            if (acc && (!pwrite || cfg_reg.lock ||
                state_reg != pld_power_pkg::ST_RUN)) begin
               pslverr = 1'b1;
            end else if (wr) begin
               preload_go = 1'b1;
            end
         end
         pld_power_pkg::SIG_LO_OFFSET: begin
            if (wr) begin
               sig_next[31:0] = pwdata;
            end
         end
         pld_power_pkg::SIG_HI_OFFSET: begin
            if (wr) begin
               sig_next[63:32] = pwdata;
            end
         end
         pld_power_pkg::STATUS_OFFSET: begin
            pslverr = wr;
         end
         pld_power_pkg::READBACK_OFFSET: begin
            pslverr = acc & (pwrite | cfg_reg.lock);
         end
         default: begin
            pslverr = acc;
         end
      endcase
      // Read mux
      if (rd_setup) begin
         prdata_next = 32'h0;
         case (paddr)
            pld_power_pkg::CTRL_OFFSET: begin
               prdata_next[4:0] = {cfg_reg.lock, cfg_reg.speed_slow,
                                   cfg_reg.sleep_en, cfg_reg.mode};
            end
            pld_power_pkg::CELL_CFG_OFFSET: begin
               prdata_next[2*NUM_CELLS-1:0] = cell_cfg_reg;
            end
            pld_power_pkg::SIG_LO_OFFSET: begin
               prdata_next = sig_reg[31:0];
            end
            pld_power_pkg::SIG_HI_OFFSET: begin
               prdata_next = sig_reg[63:32];
            end
            pld_power_pkg::STATUS_OFFSET: begin
               prdata_next[3:0] = {output_ok, clock_ok,
                  state_reg == pld_power_pkg::ST_SLEEP,
                  state_reg != pld_power_pkg::ST_CLEAR};
               prdata_next[pld_power_pkg::STATUS_CELLS_POS +: NUM_CELLS] =
                  cell_reg;
            end
            pld_power_pkg::READBACK_OFFSET: begin
               if (!cfg_reg.lock) begin
                  prdata_next[2*NUM_CELLS-1:0] = cell_cfg_reg;
               end
            end
            default: begin
               prdata_next = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_reg <= pld_power_pkg::CFG_RESET;
         cell_cfg_reg <= pld_power_pkg::CELL_CFG_RESET;
         sig_reg <= pld_power_pkg::SIG_RESET;
         prdata_reg <= 32'h0;
      end else begin
         cfg_reg <= cfg_next;
         cell_cfg_reg <= cell_cfg_next;
         sig_reg <= sig_next;
         prdata_reg <= prdata_next;
      end
   end

   // ***************************************************************
   // Power state and macrocells
   // ***************************************************************
   assign sleep_req = cfg_reg.sleep_en & sleep_pin;
   assign clk_valid_cnt = pld_power_pkg::CNT_W'(cfg_reg.speed_slow ?
      pld_power_pkg::CLK_VALID_SLOW_CYCLES :
      pld_power_pkg::CLK_VALID_FAST_CYCLES);
   assign out_valid_cnt = pld_power_pkg::CNT_W'(cfg_reg.speed_slow ?
      pld_power_pkg::OUT_VALID_SLOW_CYCLES :
      pld_power_pkg::OUT_VALID_FAST_CYCLES);
   // Board must not expect clocking before recovery elapses
   assign clock_ok = (state_reg == pld_power_pkg::ST_RUN) ||
      (state_reg == pld_power_pkg::ST_WAKE &&
       cnt_reg >= clk_valid_cnt);
   assign output_ok = (state_reg == pld_power_pkg::ST_RUN);
   assign clk_rise = clk_pin & ~clk_q_reg;
   assign io_out = out_reg;
   assign io_oe_b = oe_b_reg;
   assign array_in = array_reg;

   // Next state of sequencer, cells, pins and array inputs
   always_comb begin
      logic [1:0] kind;
      logic data;
      logic seven;
      logic reg_cell;
      logic oe_now;
      kind = 2'h0;
      data = 1'b0;
      seven = 1'b0;
      reg_cell = 1'b0;
      oe_now = 1'b0;
      state_next = state_reg;
      cnt_next = cnt_reg;
      cell_next = cell_reg;
      out_next = out_reg;
      oe_b_next = oe_b_reg;
      clk_q_next = clk_q_reg;
      oe_q_next = oe_q_reg;
      array_next = array_reg;
      case (state_reg)
         pld_power_pkg::ST_CLEAR: begin
            // Board keeps the clock quiet here, edges are discarded
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == pld_power_pkg::CNT_W'(
                pld_power_pkg::CLEAR_CYCLES - 1)) begin
               state_next = pld_power_pkg::ST_RUN;
               cnt_next = '0;
            end
         end
         pld_power_pkg::ST_RUN: begin
            if (sleep_req) begin
               state_next = pld_power_pkg::ST_SLEEP;
            end
         end
         pld_power_pkg::ST_SLEEP: begin
            cnt_next = '0;
            if (!sleep_req) begin
               state_next = pld_power_pkg::ST_WAKE;
            end
         end
         pld_power_pkg::ST_WAKE: begin
            cnt_next = cnt_reg + 1'b1;
            if (sleep_req) begin
               state_next = pld_power_pkg::ST_SLEEP;
            end else if (cnt_reg >= out_valid_cnt - 1'b1) begin
               state_next = pld_power_pkg::ST_RUN;
            end
         end
         default: begin
            state_next = pld_power_pkg::ST_CLEAR;
         end
      endcase
      // Clock and enable pins are seen only once recovered
      if (clock_ok && !sleep_req) begin
         clk_q_next = clk_pin;
         oe_q_next = ~oe_pin_b;
      end
      // Input sampling resumes as soon as sleep ends
      if (state_reg != pld_power_pkg::ST_SLEEP && !sleep_req) begin
         array_next = {cfg_reg.sleep_en ? 1'b0 : sleep_pin,
                       io_keep_next, in_keep_next};
      end
      for (int i = 0; i < NUM_CELLS; i++) begin
         kind = cell_cfg_reg[2*i +: 2];
         reg_cell = is_reg_cell(cfg_reg.mode, kind);
         seven = (cfg_reg.mode != pld_power_pkg::MODE_SIMPLE) &&
                 !reg_cell;
         data = term_sum(product_terms[8*i +: 8], seven);
         if (kind == pld_power_pkg::CELL_INPUT) begin
            oe_now = 1'b0;
         end else if (reg_cell) begin
            oe_now = oe_q_reg;
         end else if (cfg_reg.mode == pld_power_pkg::MODE_SIMPLE) begin
            oe_now = 1'b1;
         end else begin
            oe_now = product_terms[8*i+7];
         end
         if (state_reg == pld_power_pkg::ST_CLEAR) begin
            cell_next[i] = 1'b0;
            out_next[i] = 1'b1;
            oe_b_next[i] = 1'b1;
         end else if (state_reg == pld_power_pkg::ST_SLEEP || sleep_req) begin
            // Frozen: values and enables held, off outputs stay off
            cell_next[i] = cell_reg[i];
            oe_b_next[i] = oe_b_reg[i];
         end else begin
            if (preload_go && preload_mask[i]) begin
               cell_next[i] = preload_val[i];
            end else if (reg_cell && clock_ok && clk_rise) begin
               cell_next[i] = data;
            end
            // Registered pins drive the inverted flip-flop
            out_next[i] = reg_cell ? ~cell_reg[i] : data;
            oe_b_next[i] = ~oe_now;
         end
      end
   end

   // Keepers run in every state, including sleep
   always_comb begin
      for (int i = 0; i < NUM_IN; i++) begin
         in_keep_next[i] = in_driven[i] ? in_pin[i] : in_keep_reg[i];
      end
      for (int i = 0; i < NUM_CELLS; i++) begin
         if (!oe_b_reg[i]) begin
            io_keep_next[i] = out_reg[i];
         end else if (io_driven[i]) begin
            io_keep_next[i] = io_in[i];
         end else begin
            io_keep_next[i] = io_keep_reg[i];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= pld_power_pkg::ST_CLEAR;
         cnt_reg <= '0;
         cell_reg <= '0;
         out_reg <= '1;
         oe_b_reg <= '1;
         in_keep_reg <= '0;
         io_keep_reg <= '0;
         array_reg <= '0;
         clk_q_reg <= 1'b0;
         oe_q_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         cell_reg <= cell_next;
         out_reg <= out_next;
         oe_b_reg <= oe_b_next;
         in_keep_reg <= in_keep_next;
         io_keep_reg <= io_keep_next;
         array_reg <= array_next;
         clk_q_reg <= clk_q_next;
         oe_q_reg <= oe_q_next;
      end
   end

endmodule

// >>> pkg/pld_power_pkg.sv
package pld_power_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int POWERUP_CLEAR_INTERVAL_NS = 1000;
   localparam int WAKE_TO_OUTPUT_VALID_FAST_NS = 20;
   localparam int WAKE_TO_OUTPUT_VALID_SLOW_NS = 25;
   localparam int WAKE_TO_CLOCK_VALID_FAST_NS = 15;
   localparam int WAKE_TO_CLOCK_VALID_SLOW_NS = 20;

   // Longest times round down, never below one cycle
   function automatic int floor_cycles(input int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int CLEAR_CYCLES = floor_cycles(POWERUP_CLEAR_INTERVAL_NS);
   localparam int OUT_VALID_FAST_CYCLES =
      floor_cycles(WAKE_TO_OUTPUT_VALID_FAST_NS);
   localparam int OUT_VALID_SLOW_CYCLES =
      floor_cycles(WAKE_TO_OUTPUT_VALID_SLOW_NS);
   localparam int CLK_VALID_FAST_CYCLES =
      floor_cycles(WAKE_TO_CLOCK_VALID_FAST_NS);
   localparam int CLK_VALID_SLOW_CYCLES =
      floor_cycles(WAKE_TO_CLOCK_VALID_SLOW_NS);
   localparam int CNT_W = 9;

   // ***************************************************************
   // Register map (byte addresses)
   // ***************************************************************
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] CELL_CFG_OFFSET = 8'h04;
   localparam logic [7:0] PRELOAD_OFFSET = 8'h08;
   localparam logic [7:0] SIG_LO_OFFSET = 8'h0C;
   localparam logic [7:0] SIG_HI_OFFSET = 8'h10;
   localparam logic [7:0] STATUS_OFFSET = 8'h14;
   localparam logic [7:0] READBACK_OFFSET = 8'h18;

   // Control, preload and status fields
   localparam int CTRL_MODE_POS = 0;
   localparam int CTRL_SLEEP_EN_POS = 2;
   localparam int CTRL_SLOW_POS = 3;
   localparam int CTRL_LOCK_POS = 4;
   localparam int PRELOAD_MASK_POS = 8;
   localparam int STATUS_CELLS_POS = 8;

   // Architecture modes
   localparam logic [1:0] MODE_REGISTERED = 2'h0;
   localparam logic [1:0] MODE_COMPLEX = 2'h1;
   localparam logic [1:0] MODE_SIMPLE = 2'h2;

   // Macrocell kinds
   localparam logic [1:0] CELL_REG_OUT = 2'h0;
   localparam logic [1:0] CELL_COMB_IO = 2'h1;
   localparam logic [1:0] CELL_COMB_OUT = 2'h2;
   localparam logic [1:0] CELL_INPUT = 2'h3;

   // Reset values
   localparam logic [15:0] CELL_CFG_RESET = 16'h0000;
   localparam logic [63:0] SIG_RESET = 64'h0;

   typedef struct packed {
      logic lock;
      logic speed_slow;
      logic sleep_en;
      logic [1:0] mode;
   } cfg_type;

   localparam cfg_type CFG_RESET = '{1'b0, 1'b0, 1'b0, MODE_REGISTERED};

   typedef enum logic [1:0] {
      ST_CLEAR,
      ST_RUN,
      ST_SLEEP,
      ST_WAKE
   } power_state_type;

endpackage

// >>> test/board_model.sv
`timescale 1ns/1ns
module board_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Requests from the bench
   input wire logic clk_run,
   input wire logic sleep_req,
   input wire logic oe_req_b,
   input wire logic drive_req,
   input wire logic [7:0] data_req,
   // Device side of the macrocell pins
   input wire logic [7:0] io_out,
   input wire logic [7:0] io_oe_b,
   // Board pins
   output logic clk_pin,
   output logic oe_pin_b,
   output logic sleep_pin,
   output logic [7:0] in_pin,
   output logic [7:0] in_driven,
   output logic [7:0] io_in,
   output logic [7:0] io_driven
);
   // ********************
   // Board drivers
   // ********************
   logic [1:0] div_reg;
   logic [2:0] hold_reg;
   logic [7:0] float_reg;
   // Released lines flip every cycle so a stale value cannot pass
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_pin <= 1'b0;
         oe_pin_b <= 1'b1;
         sleep_pin <= 1'b0;
         in_pin <= 8'h00;
         in_driven <= 8'h00;
         div_reg <= 2'h0;
         hold_reg <= 3'h0;
         float_reg <= 8'h00;
      end else begin
         sleep_pin <= sleep_req;
         oe_pin_b <= oe_req_b;
         div_reg <= div_reg + 2'h1;
         float_reg <= ~float_reg;
         in_driven <= {8{drive_req}};
         in_pin <= drive_req ? data_req : ~in_pin;
         // Clock held still for the recovery time after sleep ends
         if (sleep_pin && !sleep_req) begin
            hold_reg <= 3'(pld_power_pkg::CLK_VALID_SLOW_CYCLES + 1);
         end else if (hold_reg != 3'h0) begin
            hold_reg <= hold_reg - 3'h1;
         end
         // Clock runs only once the bench has set up its inputs
         if (clk_run && hold_reg == 3'h0 && div_reg == 2'h3) begin
            clk_pin <= ~clk_pin;
         end
      end
   end
   // Wire level: device output wins where it drives, else the board
   assign io_driven = {8{drive_req}} & io_oe_b;
   assign io_in = (~io_oe_b & io_out) |
      (io_oe_b & (drive_req ? data_req : float_reg));
endmodule

// >>> test/pld_power_state_control_bench.sv
`timescale 1ns/1ns
module pld_power_state_control_bench;
   // ********************
   // Bench
   // ********************
   localparam logic [7:0] CTRL_A = pld_power_pkg::CTRL_OFFSET;
   localparam logic [7:0] CFG_A = pld_power_pkg::CELL_CFG_OFFSET;
   localparam logic [7:0] PRE_A = pld_power_pkg::PRELOAD_OFFSET;
   localparam logic [7:0] SLO_A = pld_power_pkg::SIG_LO_OFFSET;
   localparam logic [7:0] SHI_A = pld_power_pkg::SIG_HI_OFFSET;
   localparam logic [7:0] STA_A = pld_power_pkg::STATUS_OFFSET;
   localparam logic [7:0] RBK_A = pld_power_pkg::READBACK_OFFSET;
   logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, clk_run = 1'b0, sleep_req = 1'b0;
   logic oe_req_b = 1'b1, drive_req = 1'b1;
   logic [7:0] paddr = 8'h00, data_req = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [63:0] product_terms = 64'h0;
   logic [31:0] prdata;
   logic pready, pslverr, clk_pin, oe_pin_b, sleep_pin;
   logic [7:0] in_pin, in_driven, io_in, io_driven, io_out, io_oe_b;
   logic [7:0] ff, v, m;
   logic [16:0] array_in;
   logic [63:0] sig;
   int bad_count = 0, cmp_count = 0, cyc = 0, seed = 58213;

   pld_power_state_control uut (.*);
   board_model board (.*);

   always #2 ref_clk = ~ref_clk;

   // One APB transfer, held until pready is seen high or 16 further cycles pass
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 16) begin
         @(posedge ref_clk);
         n++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic ex);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
      chk({31'h0, er}, {31'h0, ex});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x,
      input logic ex, input logic [31:0] msk);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0, rd, er);
      chk({31'h0, er}, {31'h0, ex});
      chk(rd & msk, x & msk);
   endtask
   // Masked cells take the new value, the rest keep theirs
   function automatic logic [7:0] pre_exp(input logic [7:0] o, v, k);
      return (o & ~k) | (v & k);
   endfunction
   task automatic conclude();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // The whole sequence needs well under two thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         conclude();
      end
   end

   initial begin
      repeat (2) @(posedge ref_clk);
      chk({24'h0, io_out & io_oe_b}, 32'hFF);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      wr(PRE_A, 32'h0000_FF55, 1'b1);
      rdc(STA_A, 32'h0, 1'b0, 32'h1);
      repeat (pld_power_pkg::CLEAR_CYCLES) @(posedge ref_clk);
      rdc(STA_A, 32'h1, 1'b0, 32'hFF01);
      chk({24'h0, io_out}, 32'hFF);
      sig = {$random(seed), $random(seed)};
      wr(SLO_A, sig[31:0], 1'b0);
      wr(SHI_A, sig[63:32], 1'b0);
      rdc(SHI_A, sig[63:32], 1'b0, '1);
      rdc(8'h40, 32'h0, 1'b1, 32'h0);
      // Code 3 is not a mode, so the last one stays
      for (int k = 0; k < 4; k++) begin
         wr(CTRL_A, 32'(k), 1'b0);
         rdc(CTRL_A, (k == 3) ? 32'h2 : 32'(k), 1'b0, 32'h3);
      end
      wr(CTRL_A, 32'h0, 1'b0);
      v = 8'($random(seed));
      wr(CFG_A, {16'h0, v, ~v}, 1'b0);
      rdc(CFG_A, {16'h0, v, ~v}, 1'b0, 32'hFFFF);
      rdc(RBK_A, {16'h0, v, ~v}, 1'b0, 32'hFFFF);
      wr(CFG_A, 32'h0, 1'b0);
      oe_req_b <= 1'b0;
      ff = 8'h00;
      for (int i = 0; i < 6; i++) begin
         v = 8'($random(seed));
         m = (i == 0) ? 8'hFF : (i == 5) ? 8'h00 : 8'($random(seed));
         product_terms <= {$random(seed), $random(seed)};
         wr(PRE_A, {16'h0, m, v}, 1'b0);
         ff = pre_exp(ff, v, m);
         rdc(STA_A, {16'h0, ff, 8'h0}, 1'b0, 32'hFF00);
         chk({24'h0, io_out}, {24'h0, ~ff});
         chk({24'h0, io_oe_b}, 32'h0);
      end
      rdc(PRE_A, 32'h0, 1'b1, 32'h0);
      // Asleep with outputs off, then disturb the preload, enable, clock and data inputs
      oe_req_b <= 1'b1;
      wr(CTRL_A, 32'h4, 1'b0);
      sleep_req <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rdc(STA_A, 32'h2, 1'b0, 32'h2);
      wr(PRE_A, {16'h0, 8'hFF, ~ff}, 1'b1);
      oe_req_b <= 1'b0;
      clk_run <= 1'b1;
      data_req <= 8'($random(seed));
      repeat (20) @(posedge ref_clk);
      chk({24'h0, io_oe_b}, 32'hFF);
      chk({24'h0, io_out}, {24'h0, ~ff});
      rdc(STA_A, {16'h0, ff, 8'h0}, 1'b0, 32'hFF00);
      clk_run <= 1'b0;
      sleep_req <= 1'b0;
      repeat (pld_power_pkg::OUT_VALID_SLOW_CYCLES + 3) @(posedge ref_clk);
      rdc(STA_A, 32'h8, 1'b0, 32'hA);
      chk({24'h0, io_oe_b}, 32'h0);
      wr(CTRL_A, 32'h0, 1'b0);
      sleep_req <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk({31'h0, array_in[16]}, 32'h1);
      rdc(STA_A, 32'h0, 1'b0, 32'h2);
      sleep_req <= 1'b0;
      data_req <= 8'hA5;
      repeat (3) @(posedge ref_clk);
      drive_req <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk({24'h0, array_in[7:0]}, 32'hA5);
      ff = 8'($random(seed));
      wr(PRE_A, {16'h0, 8'hFF, ff}, 1'b0);
      wr(CTRL_A, 32'h10, 1'b0);
      rdc(RBK_A, 32'h0, 1'b1, '1);
      wr(PRE_A, {16'h0, 8'hFF, ~ff}, 1'b1);
      rdc(STA_A, {16'h0, ff, 8'h0}, 1'b0, 32'hFF00);
      wr(CTRL_A, 32'h0, 1'b0);
      rdc(CTRL_A, 32'h10, 1'b0, 32'h10);
      rdc(SLO_A, sig[31:0], 1'b0, '1);
      conclude();
   end
endmodule

// >>> test/power_state_props.sv
`timescale 1ns/1ns
module power_state_props #(
   parameter int NUM_CELLS = 8,
   parameter int NUM_IN = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Board pins
   input wire logic clk_pin,
   input wire logic oe_pin_b,
   input wire logic sleep_pin,
   input wire logic [NUM_IN-1:0] in_pin,
   input wire logic [NUM_IN-1:0] in_driven,
   // Macrocell pins and array
   input wire logic [NUM_CELLS-1:0] io_in,
   input wire logic [NUM_CELLS-1:0] io_driven,
   input wire logic [NUM_CELLS-1:0] io_out,
   input wire logic [NUM_CELLS-1:0] io_oe_b,
   input wire logic [8*NUM_CELLS-1:0] product_terms,
   input wire logic [NUM_IN+NUM_CELLS:0] array_in
);
   // ********************
   // Shadow state
   // ********************
   localparam int CLR = pld_power_pkg::CLEAR_CYCLES;
   logic [8:0] cnt_reg, cnt_next;
   logic en_reg, en_next, lk_reg, lk_next, acc, ctrl_wr;
   // Completed transfers; only accepted control writes move the sleep-enable and lock shadows
   assign acc = psel & penable & pready;
   assign ctrl_wr = acc & pwrite & ~pslverr &
      (paddr == pld_power_pkg::CTRL_OFFSET);
   // Age count saturates so a long run never re-enters the clear window
   always_comb begin
      cnt_next = (cnt_reg == 9'h1FF) ? cnt_reg : cnt_reg + 9'h001;
      en_next = ctrl_wr ? pwdata[pld_power_pkg::CTRL_SLEEP_EN_POS] : en_reg;
      lk_next = lk_reg | (ctrl_wr & pwdata[pld_power_pkg::CTRL_LOCK_POS]);
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= 9'h000;
         en_reg <= 1'b0;
         lk_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         en_reg <= en_next;
         lk_reg <= lk_next;
      end
   end
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   // Margin of two cycles keeps the exact end of clearing out of it
   property p_clear_outs;
      cnt_reg < CLR - 2 |-> io_out == '1 && io_oe_b == '1;
   endproperty
   a_clear_outs: assert property (p_clear_outs)
      else $error("outputs left their cleared level while clearing");
   property p_clear_refuse;
      cnt_reg < CLR - 2 && acc && pwrite &&
         paddr == pld_power_pkg::PRELOAD_OFFSET |-> pslverr;
   endproperty
   a_clear_refuse: assert property (p_clear_refuse)
      else $error("preload taken while clearing");
   property p_lock_readback;
      lk_reg && acc && paddr == pld_power_pkg::READBACK_OFFSET
         |-> pslverr && prdata == '0;
   endproperty
   a_lock_readback: assert property (p_lock_readback)
      else $error("readback served while locked");
   property p_lock_preload;
      lk_reg && acc && pwrite && paddr == pld_power_pkg::PRELOAD_OFFSET
         |-> pslverr;
   endproperty
   a_lock_preload: assert property (p_lock_preload)
      else $error("preload taken while locked");
   property p_sig_open;
      acc && (paddr == pld_power_pkg::SIG_LO_OFFSET ||
         paddr == pld_power_pkg::SIG_HI_OFFSET) |-> !pslverr;
   endproperty
   a_sig_open: assert property (p_sig_open)
      else $error("signature access refused");
   property p_freeze;
      en_reg && sleep_pin && $past(sleep_pin) && $past(sleep_pin, 2)
         |-> $stable(io_out) && $stable(io_oe_b) && $stable(array_in);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("pins moved while asleep");
   property p_sleep_preload;
      en_reg && sleep_pin && $past(sleep_pin) && acc && pwrite &&
         paddr == pld_power_pkg::PRELOAD_OFFSET |-> pslverr;
   endproperty
   a_sleep_preload: assert property (p_sleep_preload)
      else $error("preload taken while asleep");
   property p_pin_input;
      !en_reg && sleep_pin && cnt_reg >= CLR
         |=> array_in[NUM_IN+NUM_CELLS];
   endproperty
   a_pin_input: assert property (p_pin_input)
      else $error("sleep pin not passed to the array");
endmodule

bind pld_power_state_control power_state_props #(
   .NUM_CELLS(NUM_CELLS),
   .NUM_IN(NUM_IN)
) props (.*);
